// ===== hdl/vrc_pkg.sv
/*
  Constants, register map and state types for the vicinity RF symbol codec.
  Assumes a 20 MHz system clock and a carrier reference that is slower than half of it.
*/
package vrc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ       = 20000;
  localparam int CLK_PERIOD_NS = 1000000 / CLK_KHZ;
  localparam int PWRUP_NS      = 100000;                   // 0.1 ms
  localparam int GUARD_NS      = 311500;                   // 311.5 us
  localparam int PWRUP_CYC     = PWRUP_NS / CLK_PERIOD_NS;
  localparam int GUARD_CYC     = GUARD_NS / CLK_PERIOD_NS;
  localparam int BLK_W         = 13;

  // Request side, in carrier cycles
  localparam int SLOT_TICKS    = 256;                      // 18.88 us slot
  localparam int HALF_TICKS    = SLOT_TICKS / 2;
  localparam int SOF256_HALVES = 4;
  localparam int SOF4_HALVES   = 6;
  localparam int SOF_TOL       = 64;
  localparam int SOF_TIMEOUT   = 8 * HALF_TICKS;
  localparam int SOFEND_TICKS  = 2 * HALF_TICKS;

  // Response side, in carrier cycles per subcarrier pulse and pulses per half-bit
  localparam logic [4:0] PER_FS1   = 5'h1f;                // period minus one, carrier/32
  localparam logic [4:0] PER_FS2   = 5'h1b;                // period minus one, carrier/28
  localparam logic [5:0] NP_FS1    = 6'h08;
  localparam logic [5:0] NP_FS2    = 6'h09;
  localparam int         LOW_SHIFT = 2;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam int         CTRL_RX_EN  = 0;
  localparam int         CTRL_FAST   = 1;
  localparam logic [1:0] CTRL_RST    = 2'h1;
  localparam int         TX_LAST_BIT = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RX_IDLE, RX_SOF, RX_SOFEND, RX_DATA} vrc_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_HALF1, TX_HALF2} vrc_tx_state_t;

endpackage

// ===== hdl/vrc_codec.sv
/*
  Vicinity RF symbol codec: pulse-position request decoder and Manchester
  subcarrier response encoder, with an AXI4-Lite register slave.
  Assumes a demodulated pause level and a carrier reference from the analog
  front end, both asynchronous to clk, and software that frames responses.
*/
// What this block does
// RL1 - Decode pauses of either modulation depth
// RL2 - 256-slot mode: slot index gives byte value
// RL3 - Pause sampled in second slot half
// RL4 - First slot 00h, last slot FFh
// RL5 - 4-slot mode: two bits, LSB pair first
// RL6 - Accept requests 311.5 us after response
// RL7 - Receiver ready 0.1 ms after power-up
// RL8 - Start delimiter selects coding; common end
// RL9 - Delimiters found by code violation
// RL10 - First flag bit picks subcarrier count
// RL11 - Subcarriers carrier/32, carrier/28, phase continuous
// RL12 - Second flag bit picks rate; fast doubles
// RL13 - Bit periods follow rate and subcarriers
// RL14 - Manchester; low rate times four
// RL15 - High one-sub zero: pulses then gap
// RL16 - High one-sub one: gap then pulses
// RL17 - Fast one-sub halves counts and times
// RL18 - Low one-sub zero: 32 pulses, gap
// RL19 - Low one-sub one: gap, 32 pulses
// RL20 - Low fast: 16 pulses, 37.76 us gap
// RL21 - High two-sub: 8 fs1 / 9 fs2
// RL22 - Low two-sub: 32 fs1 / 36 fs2
// RL23 - Fast replies always use one subcarrier
`timescale 1ns/1ps

module vrc_codec #(
  parameter int GUARD_CYCLES = vrc_pkg::GUARD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       carrier,
  input  wire logic       rx_pause,
  output      logic       load_mod,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output      logic       s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output      logic       s_axi_wready,
  output      logic [1:0] s_axi_bresp,
  output      logic       s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output      logic       s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0] s_axi_rresp,
  output      logic       s_axi_rvalid,
  input  wire logic       s_axi_rready
);
  import vrc_pkg::*;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_RXDATA) ||
               (a == ADDR_TXDATA);
  endfunction

  // ----------------------------------------------------------------------
  // Synchronisers and carrier tick
  // ----------------------------------------------------------------------
  logic [1:0] car_sync;
  logic       car_last;
  logic [1:0] pau_sync;
  logic       pau_prev;
  logic       pau_taken;

  // Both pins are asynchronous; only the second stage is ever looked at
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      car_sync <= 2'h0;
      car_last <= 1'b0;
      pau_sync <= 2'h0;
    end else begin
      car_sync <= {car_sync[0], carrier};
      car_last <= car_sync[1];
      pau_sync <= {pau_sync[0], rx_pause};
    end
  end

  wire tick      = car_sync[1] & ~car_last;
  wire pause_lvl = pau_sync[1];
  // A pause must persist over two carrier edges; a shallow dip rejects glitches
  wire pau_evt   = tick & pause_lvl & pau_prev & ~pau_taken;   // RL1

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pau_prev  <= 1'b0;
      pau_taken <= 1'b0;
    end else if (tick) begin
      pau_prev  <= pause_lvl;
      pau_taken <= pause_lvl & pau_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Register state and receive gating
  // ----------------------------------------------------------------------
  logic [1:0]       ctrl;
  logic [BLK_W-1:0] blk;
  vrc_tx_state_t    tx_state;
  logic             tx_last;
  logic             tx_done;
  wire              tx_busy  = (tx_state != TX_IDLE);
  wire              rx_ready = (blk == '0) & ~tx_busy & ctrl[CTRL_RX_EN];

  // Blocking window: power-up delay after reset, guard after a final byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blk <= BLK_W'(PWRUP_CYC);                               // RL7
    end else if (tx_done && tx_last) begin
      blk <= BLK_W'(GUARD_CYCLES);                            // RL6
    end else if (blk != '0) begin
      blk <= blk - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Request decoder
  // ----------------------------------------------------------------------
  vrc_rx_state_t rx_state;
  logic [15:0]   pos;
  logic          mode256;
  logic          got;
  logic [1:0]    pair;
  logic [7:0]    shreg;
  logic          first_byte;
  logic          two_sub;
  logic          high_rate;
  logic [7:0]    rx_byte;
  logic          rx_valid;

  // Spacing of the second delimiter pause tells the coding mode apart
  wire is256 = (pos >= 16'(SOF256_HALVES * HALF_TICKS - SOF_TOL)) &&
               (pos <= 16'(SOF256_HALVES * HALF_TICKS + SOF_TOL));    // RL9
  wire is4   = (pos >= 16'(SOF4_HALVES * HALF_TICKS - SOF_TOL)) &&
               (pos <= 16'(SOF4_HALVES * HALF_TICKS + SOF_TOL));      // RL9
  wire pos_wrap  = mode256 ? (pos == 16'hffff) : (pos[9:0] == 10'h3ff);
  wire second_hf = pos[7];                                            // RL3
  wire data_take = (rx_state == RX_DATA) & pau_evt & second_hf & ~got;
  wire byte_done = data_take & (mode256 | (pair == 2'h3));
  // Slot index is the value; pairs shift in from the top so the first lands lowest
  wire [7:0] next_byte = mode256 ? pos[15:8] : {pos[9:8], shreg[7:2]}; // RL2 RL4 RL5

  // Frame sequencer: delimiter, then a symbol grid counted in carrier cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= RX_IDLE;
      pos      <= 16'h0;
      mode256  <= 1'b0;
      got      <= 1'b0;
    end else if (!rx_ready) begin
      rx_state <= RX_IDLE;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (pau_evt) begin
            rx_state <= RX_SOF;
            pos      <= 16'h0;
          end
        end
        RX_SOF: begin
          if (pau_evt && (is256 || is4)) begin
            rx_state <= RX_SOFEND;
            mode256  <= is256;                                // RL8
            pos      <= 16'h0;
          end else if (pau_evt || pos > 16'(SOF_TIMEOUT)) begin
            rx_state <= RX_IDLE;
          end else if (tick) begin
            pos <= pos + 16'h1;
          end
        end
        RX_SOFEND: begin
          if (tick && pos == 16'(SOFEND_TICKS - 1)) begin
            rx_state <= RX_DATA;
            pos      <= 16'h0;
            got      <= 1'b0;
          end else if (tick) begin
            pos <= pos + 16'h1;
          end
        end
        RX_DATA: begin
          // A pause in a first half-slot is the code violation closing the frame
          if (pau_evt && (!second_hf || got)) begin
            rx_state <= RX_IDLE;                              // RL8 RL9
          end else if (tick) begin
            if (pos_wrap) begin
              pos <= 16'h0;
              got <= 1'b0;
              if (!got && !pau_evt) begin
                rx_state <= RX_IDLE;
              end
            end else begin
              pos <= pos + 16'h1;
              got <= got | pau_evt;
            end
          end
        end
      endcase
    end
  end

  wire rd_rx = s_axi_arvalid & ~s_axi_rvalid & (s_axi_araddr == ADDR_RXDATA);

  // Byte assembly and header flag capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pair       <= 2'h0;
      shreg      <= 8'h0;
      first_byte <= 1'b0;
      two_sub    <= 1'b0;
      high_rate  <= 1'b0;
      rx_byte    <= 8'h0;
      rx_valid   <= 1'b0;
    end else begin
      if (rx_state == RX_SOFEND) begin
        pair       <= 2'h0;
        first_byte <= 1'b1;
      end else if (data_take) begin
        pair  <= pair + 2'h1;                                 // RL5
        shreg <= next_byte;
      end
      if (byte_done) begin
        rx_byte    <= next_byte;
        first_byte <= 1'b0;
      end
      if (byte_done && first_byte) begin
        two_sub   <= next_byte[0];                            // RL10
        high_rate <= next_byte[1];                            // RL12
      end
      // A byte landing in the same cycle as the read keeps its flag
      rx_valid <= byte_done | (rx_valid & ~rd_rx);
    end
  end

  // ----------------------------------------------------------------------
  // Response encoder
  // ----------------------------------------------------------------------
  logic [7:0] tx_sh;
  logic [2:0] tx_bit;
  logic [4:0] tcnt;
  logic [5:0] pcnt;
  logic       t_two;
  logic       t_low;
  logic       t_fast;
  // Set by a start until the first carrier tick, so the first pulse is full length
  logic       tx_arm;

  wire wr_go    = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire tx_start = wr_go & (s_axi_awaddr == ADDR_TXDATA) & s_axi_wstrb[0] & ~tx_busy;
  wire half1    = (tx_state == TX_HALF1);
  wire cur_bit  = tx_sh[0];
  // Logic 0 puts the carrier/32 burst first; logic 1 puts it last
  wire use_fs2  = t_two & (half1 ? cur_bit : ~cur_bit);             // RL21 RL22
  wire mod_on   = t_two | (half1 ? ~cur_bit : cur_bit);             // RL14 RL15 RL16
  wire [4:0] per_m1  = use_fs2 ? PER_FS2 : PER_FS1;                 // RL11
  wire [5:0] np_base = use_fs2 ? NP_FS2 : NP_FS1;
  // Low rate multiplies pulse counts by four; fast halves them
  wire [5:0] np_low  = t_low ? 6'(np_base << LOW_SHIFT) : np_base;  // RL14 RL18 RL19 RL22
  wire [5:0] np_all  = t_fast ? (np_low >> 1) : np_low;             // RL17 RL20
  wire pulse_end = (tcnt == per_m1);
  wire half_end  = pulse_end & (pcnt == np_all - 6'h1);             // RL13
  // Square subcarrier: high for the first half of each pulse period
  wire next_load = tx_busy & ~tx_arm & mod_on & (tcnt <= (per_m1 >> 1)); // RL11

  assign tx_done = tick & (tx_state == TX_HALF2) & half_end & (tx_bit == 3'h7);

  // Bit sequencer; counters restart only at pulse edges, so a switch of
  // subcarrier keeps the phase continuous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= TX_IDLE;
      tx_sh    <= 8'h0;
      tx_bit   <= 3'h0;
      tx_last  <= 1'b0;
      tcnt     <= 5'h0;
      pcnt     <= 6'h0;
      t_two    <= 1'b0;
      t_low    <= 1'b0;
      t_fast   <= 1'b0;
      load_mod <= 1'b0;
      tx_arm   <= 1'b0;
    end else begin
      load_mod <= next_load;
      if (tx_start) begin
        tx_state <= TX_HALF1;
        tx_sh    <= s_axi_wdata[7:0];
        tx_last  <= s_axi_wdata[TX_LAST_BIT] & s_axi_wstrb[1];
        tx_bit   <= 3'h0;
        tcnt     <= 5'h0;
        pcnt     <= 6'h0;
        t_fast   <= ctrl[CTRL_FAST];                          // RL12
        t_two    <= two_sub & ~ctrl[CTRL_FAST];               // RL10 RL23
        t_low    <= ~high_rate;                               // RL12
        tx_arm   <= 1'b1;
      end else if (tick && tx_arm) begin
        // A start lands anywhere between ticks; counting from here keeps
        // every pulse and half-bit on the carrier grid
        tx_arm <= 1'b0;                                       // RL11 RL13
      end else if (tick && tx_busy) begin
        tcnt <= pulse_end ? 5'h0 : tcnt + 5'h1;
        if (half_end) begin
          pcnt <= 6'h0;
          if (half1) begin
            tx_state <= TX_HALF2;
          end else if (tx_bit == 3'h7) begin
            tx_state <= TX_IDLE;
          end else begin
            tx_state <= TX_HALF1;
            tx_sh    <= {1'b0, tx_sh[7:1]};
            tx_bit   <= tx_bit + 3'h1;
          end
        end else if (pulse_end) begin
          pcnt <= pcnt + 6'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  // Address and data are taken together; one beat each, answered next cycle
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;

  wire [31:0] status_word = {26'h0, high_rate, two_sub, tx_busy, rx_ready, mode256,
                             rx_state != RX_IDLE};
  wire [31:0] rd_word =
    (s_axi_araddr == ADDR_CTRL)   ? {30'h0, ctrl} :
    (s_axi_araddr == ADDR_STATUS) ? status_word :
    (s_axi_araddr == ADDR_RXDATA) ? {23'h0, rx_valid, rx_byte} : 32'h0;

  // Write response and control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl         <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_hit(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
        ctrl <= s_axi_wdata[1:0];
      end
    end
  end

  // Read response
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== bench/vrc_codec_chk.sv
/* Port assertions for the symbol codec.
   Assumes a 20 MHz clk and a carrier tick of exactly eight clk cycles. */
`timescale 1ns/1ps
module vrc_codec_chk import vrc_pkg::*; #(
  parameter int GUARD_CYCLES = GUARD_CYC
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        load_mod,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] hi_run;
  logic [15:0] lo_run;

  // Run lengths of load_mod; low run saturates so long gaps stay large
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_run <= 16'h0;
      lo_run <= 16'hffff;
    end else if (load_mod) begin
      hi_run <= hi_run + 16'h1;
      lo_run <= 16'h0;
    end else begin
      hi_run <= 16'h0;
      if (lo_run != 16'hffff) lo_run <= lo_run + 16'h1;
    end
  end

  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered one cycle after it was taken");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  wr_pair_a: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
    else $error("address taken without its data");
  bad_wr_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr > 8'h0c
    |=> s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered one cycle after it was taken");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  bad_rd_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h0c
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  pulse_width_a: assert property ($fell(load_mod) |-> hi_run == 16'h80 || hi_run == 16'h70)
    else $error("subcarrier pulse has wrong high time");
  pulse_gap_a: assert property ($rose(load_mod) |-> lo_run == 16'h80 || lo_run == 16'h70
    || lo_run >= 16'h480) else $error("subcarrier low time off the grid");
endmodule

bind vrc_codec vrc_codec_chk #(.GUARD_CYCLES(GUARD_CYCLES)) vrc_codec_chk_inst (.*);

// ===== bench/vrc_reader_model.sv
/* Reader stand-in: free-running carrier reference and request pauses.
   Assumes the codec samples both lines against its own clock. */
`timescale 1ns/1ps
module vrc_reader_model (
  output logic carrier,
  output logic rx_pause
);
  // ----------------------------------------------------------------------
  // Carrier and pauses
  // ----------------------------------------------------------------------
  int n;
  int base;

  // The RF carrier runs free; offset so its edges never meet clk edges
  initial begin
    carrier = 1'b0;
    rx_pause = 1'b0;
    n = 0;
    #10;
    forever begin
      #200 carrier = ~carrier;
      if (carrier) n++;
    end
  end

  // Pause raised at frame tick t; either depth reaches us as the same level
  task automatic pz(input int t);
    while (n < base + t) @(negedge carrier);
    rx_pause = 1'b1;
    repeat (4) @(negedge carrier);
    rx_pause = 1'b0;
  endtask

  // Delimiter pair, data pauses late in their slots, then an early end pause
  task automatic frame(input bit four, input logic [7:0] v);
    int s;
    int g;
    s = four ? 768 : 512;
    @(negedge carrier);
    base = n;
    pz(0);
    pz(s);
    g = s + 446;
    if (four) begin
      for (int j = 0; j < 4; j++) pz(g + 256 * (4 * j + ((v >> (2 * j)) & 3)));
      pz(g + 256 * 16 - 128);
    end else begin
      pz(g + 256 * v);
      pz(g + 256 * (v + 1) - 128);
    end
  endtask
endmodule

// ===== bench/tb_top.sv
/* Self-checking bench for the symbol codec.
   Assumes the package, checker and reader model are compiled first. */
`timescale 1ns/1ps
module tb_top;
  import vrc_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam int GUARD = 400; // Short guard keeps the run brief
  logic        clk, rstn, carrier, rx_pause, load_mod;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          n_mismatch, comparisons;

  vrc_codec #(.GUARD_CYCLES(GUARD)) vrc_codec_inst (.*);
  vrc_reader_model vrc_reader_model_inst (.*);

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  // Waits to a falling edge where the line is high; the next rise takes it
  task automatic hs(ref logic s);
    do @(negedge clk); while (!s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hs(s_axi_awready);
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    hs(s_axi_bvalid);
    chk({30'h0, s_axi_bresp}, {30'h0, a > 8'h0c ? RESP_SLVERR : RESP_OKAY});
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  // Read one word and compare the masked bits and the response
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hs(s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    hs(s_axi_rvalid);
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, a > 8'h0c ? RESP_SLVERR : RESP_OKAY});
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_pwrup;
    rd(ADDR_CTRL, 32'hffffffff, 32'h1);
    rd(8'h10, 32'hffffffff, 32'h0);
    wr(8'h14, 32'h0, 4'hf);
    rd(ADDR_STATUS, 32'h4, 32'h0);
    repeat (2000) @(posedge clk);
    rd(ADDR_STATUS, 32'h4, 32'h4);
  endtask

  // One request frame; a read of the byte clears its valid bit
  task automatic t_rx(input bit four, input logic [7:0] v, input logic [31:0] st);
    vrc_reader_model_inst.frame(four, v);
    repeat (100) @(posedge clk);
    rd(ADDR_RXDATA, 32'h1ff, {23'h0, 1'b1, v});
    rd(ADDR_RXDATA, 32'h100, 32'h0);
    rd(ADDR_STATUS, 32'h37, st);
  endtask

  // Count rising edges and high samples of load_mod over len clk cycles
  task automatic win(input int len, inout logic p, output int r, output int hi);
    r = 0;
    hi = 0;
    repeat (len) begin
      if (load_mod === 1'b1) begin
        hi++;
        if (!p) r++;
      end
      p = load_mod;
      @(posedge clk) #1;
    end
  endtask

  // Fast high-rate reply with two subcarriers asked for: one subcarrier must be used
  task automatic t_tx;
    int r;
    int hi;
    int e;
    logic p;
    wr(ADDR_CTRL, 32'h3, 4'hf);
    wr(ADDR_TXDATA, 32'h15a, 4'h3);
    for (int k = 0; k < 200 && load_mod !== 1'b1; k++) @(posedge clk) #1;
    p = 1'b0;
    for (int h = 0; h < 16; h++) begin
      win(1024, p, r, hi);
      e = (((8'h5a >> (h / 2)) & 8'h1) == (h % 2)) ? 4 : 0;
      chk(r, e);
      chk(hi, e * 128);
    end
    @(posedge clk);
    rd(ADDR_STATUS, 32'h4, 32'h0);
    repeat (GUARD + 20) @(posedge clk);
    rd(ADDR_STATUS, 32'h4, 32'h4);
  endtask

  // High-rate two-subcarrier reply: a logic 0 is 8 carrier/32 then 9 carrier/28 pulses;
  // each square pulse is high for half its period, 16 or 14 ticks of 8 clk
  task automatic t_two;
    int r;
    int hi;
    logic p;
    wr(ADDR_CTRL, 32'h1, 4'hf);
    wr(ADDR_TXDATA, 32'h0, 4'h1);
    for (int k = 0; k < 200 && load_mod !== 1'b1; k++) @(posedge clk) #1;
    p = 1'b0;
    win(2048, p, r, hi);
    chk(r, 8);
    chk(hi, 1024);
    win(2016, p, r, hi);
    chk(r, 9);
    chk(hi, 1008);
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog beyond the expected 3.7 ms of traffic, under 100000 clk cycles
  initial begin
    #4500000;
    n_mismatch++;
    results;
  end

  initial begin
    rstn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_pwrup;
    t_rx(1'b0, 8'h00, 32'h06);
    t_rx(1'b1, 8'he3, 32'h34);
    t_tx;
    t_two;
    results;
  end
endmodule
